// >>> acef_params.svh
`ifndef ACEF_PARAMS_SVH
`define ACEF_PARAMS_SVH
`define ACEF_SEL_W        4
`define ACEF_SEL_GND      4'h8
`define ACEF_SEL_HALFREF  4'h9
`define ACEF_SEL_FULLREF  4'ha
`define ACEF_SEL_HALFPAD  4'hb
`define ACEF_SEL_PIN_MAX  4'h5
`define ACEF_PER_W        3
`define ACEF_BASE_CLKS    13'h0020
`define ACEF_BASE_BITS    5'h07
`define ACEF_SYS_MHZ      100
`define ACEF_FAST_MHZ     6
`define ACEF_SLOW_MHZ     1
`define ACEF_FAST_DIV     (`ACEF_SYS_MHZ / `ACEF_FAST_MHZ)
`define ACEF_SLOW_DIV     (`ACEF_SYS_MHZ / `ACEF_SLOW_MHZ)
`define ACEF_SAT_POS      16'h7fff
`define ACEF_SAT_NEG      16'h8000
`define ACEF_FLAG_OVF     0
`define ACEF_FLAG_SAT     1
`define ACEF_FLAG_FULL    2
`define ACEF_FLAG_HALF    3
`define ACEF_FLAG_DATA    4
`define ACEF_NFLAGS       5
`endif

// >>> acef_pkg.sv
`include "acef_params.svh"
package acef_pkg;
  typedef logic [`ACEF_NFLAGS-1:0] acef_flags_t;
  typedef enum logic [1:0] {
    ACEF_IDLE    = 2'b00,
    ACEF_DISCARD = 2'b01,
    ACEF_RUN     = 2'b10
  } acef_phase_e;
  typedef struct packed {
    logic [`ACEF_SEL_W-1:0] positive_input_select;
    logic [`ACEF_SEL_W-1:0] negative_input_select;
    logic                   slow_sample_clock_select;
    logic [`ACEF_PER_W-1:0] period;
  } acef_cfg_s;
  typedef struct packed {
    logic [5:0] pins;
    logic       gnd;
    logic       half_ref;
    logic       full_ref;
    logic       half_pad;
  } acef_route_s;
  typedef struct packed {
    acef_phase_e  phase;
    acef_cfg_s    cfg;
    acef_flags_t  flags;
    acef_flags_t  mask;
    logic [6:0]   div;
    logic [12:0]  clks;
    logic         samp_tick;
    logic [15:0]  data;
    logic         ready;
  } acef_state_s;
endpackage : acef_pkg

// >>> acef_ctrl.sv
// Contract
// RQ1: select codes decode to pins and internal sources
// RQ2: single-ended uses negative code nine
// RQ3: clear bit picks 6 MHz, set 1 MHz
// RQ4: sample length is 32 shifted by period
// RQ5: results left-aligned in 16-bit word
// RQ6: significant bits equal seven plus period
// RQ7: timing independent of system oscillator choice
// RQ8: overflow when result ready, dma not accepting
// RQ9: saturation when gain product leaves 16-bit
// RQ10: full flag on dma final buffer write
// RQ11: half flag on dma first-half final write
// RQ12: data flag when new result available
// RQ13: write one clears flag, zero ignored
// RQ14: flag interrupts only where mask is one
// RQ15: polled use writes zero mask
// RQ16: stop dma before changing configuration
// RQ17: clear overflow right after restarting dma
// RQ18: clamp gain product to 16-bit extremes
// RQ19: discard first conversion after enable or config
// RQ20: irq ors masked flags, set beats clear
// RQ21: flags, mask, config reset zero; sticky
`timescale 1ns/10ps
`default_nettype none
`include "acef_params.svh"
module acef_ctrl
  import acef_pkg::*;
#(
  parameter int FAST_DIV = `ACEF_FAST_DIV,
  parameter int SLOW_DIV = `ACEF_SLOW_DIV
) (
  input  wire logic               sys_clk,       // system clock
  input  wire logic               rst,           // async reset, high
  input  wire logic               enable,        // converter enable
  input  wire logic               cfg_wr,        // config write strobe
  input  wire acef_pkg::acef_cfg_s cfg_wdata,    // config write data
  output var  acef_pkg::acef_cfg_s cfg_rdata,    // config readback
  input  wire logic               mask_wr,       // mask write strobe
  input  wire acef_pkg::acef_flags_t mask_wdata, // mask write data
  output var  acef_pkg::acef_flags_t converter_event_mask,  // mask
  input  wire logic               flag_wr,       // flag clear strobe
  input  wire acef_pkg::acef_flags_t flag_wdata, // ones clear
  output var  acef_pkg::acef_flags_t converter_event_flags, // flags
  output logic                    irq,           // interrupt request
  output var  acef_pkg::acef_route_s pos_route,  // positive routing
  output var  acef_pkg::acef_route_s neg_route,  // negative routing
  output logic                    sample_clk_en, // sampling clock tick
  input  wire logic               conv_done,     // modulator result pulse
  input  wire logic [15:0]        conv_raw,      // raw signed result
  input  wire logic [31:0]        gain_product,  // signed gain product
  input  wire logic               dma_accepting, // dma taking data
  input  wire logic               dma_last_write,// dma wrote last slot
  input  wire logic               dma_half_write,// dma wrote half slot
  output logic [15:0]             result_data,   // corrected result
  output logic                    result_valid,  // new result pulse
  output logic [4:0]              sig_bits,      // significant bits
  output logic [12:0]             sample_clks    // clocks per sample
);
  import acef_pkg::*;

  ////////////////////////////////////////////////////////////////////
  function automatic acef_route_s decode(input logic [3:0] code);
    acef_route_s r;
    r = '0;
    if (code <= `ACEF_SEL_PIN_MAX) r.pins[code[2:0]] = 1'b1; // RQ1
    r.gnd      = (code == `ACEF_SEL_GND);     // RQ1
    r.half_ref = (code == `ACEF_SEL_HALFREF); // RQ1
    r.full_ref = (code == `ACEF_SEL_FULLREF); // RQ1
    r.half_pad = (code == `ACEF_SEL_HALFPAD); // RQ1
    return r;
  endfunction : decode

  function automatic logic [15:0] clamp(input logic [31:0] p);
    if ($signed(p) > $signed(32'sh00007fff)) return `ACEF_SAT_POS;
    if ($signed(p) < $signed(-32'sh00008000)) return `ACEF_SAT_NEG;
    return p[15:0];
  endfunction : clamp

  ////////////////////////////////////////////////////////////////////
  acef_state_s s_r, s_nxt;
  logic [6:0]  div_top;
  logic        sat;
  logic        new_result;
  acef_flags_t set_ev;
  logic [15:0] lmask;

  // divisor is taken from sys_clk only, so oscillator swaps upstream
  // of sys_clk do not alter sample timing
  assign div_top = s_r.cfg.slow_sample_clock_select         // RQ3 RQ7
                 ? 7'(SLOW_DIV - 1) : 7'(FAST_DIV - 1);
  assign sample_clks = `ACEF_BASE_CLKS << s_r.cfg.period;   // RQ4
  assign sig_bits = `ACEF_BASE_BITS + 5'(s_r.cfg.period);   // RQ6
  assign lmask = ~(16'hffff >> sig_bits);                   // RQ5
  assign sat = ($signed(gain_product) > $signed(32'sh00007fff))
            || ($signed(gain_product) < $signed(-32'sh00008000));
  assign new_result = conv_done && (s_r.phase == ACEF_RUN);

  always_comb begin
    set_ev = '0;
    set_ev[`ACEF_FLAG_OVF]  = new_result && !dma_accepting; // RQ8
    set_ev[`ACEF_FLAG_SAT]  = new_result && sat;            // RQ9
    set_ev[`ACEF_FLAG_FULL] = dma_last_write;               // RQ10
    set_ev[`ACEF_FLAG_HALF] = dma_half_write;               // RQ11
    set_ev[`ACEF_FLAG_DATA] = new_result;                   // RQ12
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.samp_tick = 1'b0;
    s_nxt.ready = 1'b0;
    if (cfg_wr) s_nxt.cfg = cfg_wdata;
    if (mask_wr) s_nxt.mask = mask_wdata;
    // set wins over a same-cycle clear
    s_nxt.flags = (s_r.flags & ~(flag_wr ? flag_wdata : '0)) // RQ13
                | set_ev;                                    // RQ20 RQ21
    if (s_r.div >= div_top) begin
      s_nxt.div = '0;
      s_nxt.samp_tick = 1'b1;
      // clks counts sampling clocks within one sample length
      if (s_r.clks >= sample_clks - 13'h0001) s_nxt.clks = '0; // RQ4
      else s_nxt.clks = s_r.clks + 13'h0001;
    end else begin
      s_nxt.div = s_r.div + 7'h01;
    end
    // a new configuration starts a fresh sample
    if (cfg_wr) s_nxt.clks = '0;
    case (s_r.phase)
      ACEF_IDLE: begin
        if (enable) s_nxt.phase = ACEF_DISCARD;
      end
      ACEF_DISCARD: begin
        if (conv_done) s_nxt.phase = ACEF_RUN;  // RQ19
      end
      ACEF_RUN: begin
        if (new_result) begin
          s_nxt.data  = clamp(gain_product) & lmask; // RQ18 RQ5
          s_nxt.ready = 1'b1;
        end
      end
      default: s_nxt.phase = ACEF_IDLE;
    endcase
    if (!enable) s_nxt.phase = ACEF_IDLE;
    else if (cfg_wr && s_r.phase != ACEF_IDLE)
      s_nxt.phase = ACEF_DISCARD;                // RQ19
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) s_r <= '0;                          // RQ21
    else s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  assign cfg_rdata = s_r.cfg;
  assign converter_event_mask = s_r.mask;
  assign converter_event_flags = s_r.flags;
  assign irq = |(s_r.flags & s_r.mask);          // RQ14 RQ20
  assign pos_route = decode(s_r.cfg.positive_input_select); // RQ1
  assign neg_route = decode(s_r.cfg.negative_input_select); // RQ1
  assign sample_clk_en = s_r.samp_tick;          // RQ3
  assign result_data = s_r.data;
  assign result_valid = s_r.ready;

  ////////////////////////////////////////////////////////////////////
  sequence s_first_done;
    s_r.phase == ACEF_DISCARD && conv_done && enable && !cfg_wr;
  endsequence

  property p_ovf;
    @(posedge sys_clk) disable iff (rst)
    new_result && !dma_accepting |=> converter_event_flags[0];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not set"); // RQ8

  property p_sat;
    @(posedge sys_clk) disable iff (rst)
    new_result && sat |=> converter_event_flags[1];
  endproperty
  a_sat: assert property (p_sat) else $error("sat not set"); // RQ9

  property p_full;
    @(posedge sys_clk) disable iff (rst)
    dma_last_write |=> converter_event_flags[2];
  endproperty
  a_full: assert property (p_full) else $error("full not set"); // RQ10

  property p_half;
    @(posedge sys_clk) disable iff (rst)
    dma_half_write |=> converter_event_flags[3];
  endproperty
  a_half: assert property (p_half) else $error("half not set"); // RQ11

  property p_data;
    @(posedge sys_clk) disable iff (rst)
    new_result |=> converter_event_flags[4] && result_valid;
  endproperty
  a_data: assert property (p_data) else $error("data not set"); // RQ12

  property p_clear;
    @(posedge sys_clk) disable iff (rst)
    flag_wr && flag_wdata[4] && !set_ev[4] |=> !converter_event_flags[4];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // RQ13

  property p_sticky;
    @(posedge sys_clk) disable iff (rst)
    converter_event_flags[0] && !(flag_wr && flag_wdata[0])
      |=> converter_event_flags[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost"); // RQ21

  property p_irq;
    @(posedge sys_clk) disable iff (rst)
    |(set_ev & converter_event_mask) && !mask_wr |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // RQ14 RQ20

  property p_span;
    @(posedge sys_clk) disable iff (rst)
    s_r.clks < sample_clks;
  endproperty
  a_span: assert property (p_span) else $error("sample count wrong"); // RQ4

  property p_discard;
    @(posedge sys_clk) disable iff (rst)
    s_first_done |-> !result_valid ##1 !result_valid;
  endproperty
  a_discard: assert property (p_discard) else $error("no discard"); // RQ19

  property p_clamp;
    @(posedge sys_clk) disable iff (rst)
    new_result && $signed(gain_product) > $signed(32'sh00007fff)
      |=> result_data[15] == 1'b0 && result_data[14] == 1'b1;
  endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp"); // RQ18

  property p_bits;
    @(posedge sys_clk) disable iff (rst)
    sig_bits == 5'h07 + 5'(cfg_rdata.period)
      && sample_clks == (13'h0020 << cfg_rdata.period);
  endproperty
  a_bits: assert property (p_bits) else $error("period wrong"); // RQ4 RQ6
endmodule : acef_ctrl
`default_nettype wire

// >>> tb_adc_config_and_event_flags.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_config_and_event_flags;
  import acef_pkg::*;
  logic        sys_clk      = 1'b0;
  logic        rst          = 1'b1;
  logic        enable       = 1'b0;
  logic        cfg_wr       = 1'b0;
  acef_cfg_s   cfg_wdata    = '0;
  acef_cfg_s   cfg_rdata;
  logic        mask_wr      = 1'b0;
  acef_flags_t mask_wdata   = '0;
  acef_flags_t mask_q;
  logic        flag_wr      = 1'b0;
  acef_flags_t flag_wdata   = '0;
  acef_flags_t flags;
  logic        irq;
  acef_route_s pos_route;
  acef_route_s neg_route;
  logic        tick;
  logic        conv_done    = 1'b0;
  logic [31:0] gain_product = '0;
  logic        dma_acc      = 1'b0;
  logic        dma_last     = 1'b0;
  logic        dma_half     = 1'b0;
  logic [15:0] result_data;
  logic        result_valid;
  logic [4:0]  sig_bits;
  logic [12:0] sample_clks;
  int          fails        = 0;
  int          checked      = 0;
  int          cyc          = 0;
  int          n;
  acef_ctrl #(.FAST_DIV(16), .SLOW_DIV(100)) DUT (
    .sys_clk(sys_clk), .rst(rst), .enable(enable), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata), .converter_event_mask(mask_q),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata),
    .converter_event_flags(flags), .irq(irq), .pos_route(pos_route),
    .neg_route(neg_route), .sample_clk_en(tick), .conv_done(conv_done),
    .conv_raw(16'h0000), .gain_product(gain_product),
    .dma_accepting(dma_acc), .dma_last_write(dma_last),
    .dma_half_write(dma_half), .result_data(result_data),
    .result_valid(result_valid), .sig_bits(sig_bits),
    .sample_clks(sample_clks));
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task wr_cfg(input logic [3:0] p, input logic [3:0] m, input logic s,
              input logic [2:0] per);
    @(negedge sys_clk);
    cfg_wdata = '{p, m, s, per};
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask : wr_cfg
  // clr high writes the flag clear strobe, low the mask
  task wr_ev(input logic clr, input acef_flags_t v);
    @(negedge sys_clk);
    flag_wdata = v;
    mask_wdata = v;
    flag_wr = clr;
    mask_wr = !clr;
    @(negedge sys_clk);
    flag_wr = 1'b0;
    mask_wr = 1'b0;
  endtask : wr_ev
  task conv(input logic [31:0] gp);
    @(negedge sys_clk);
    gain_product = gp;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
  endtask : conv
  // first pass syncs to a tick, second counts the cycles between ticks
  task measure;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (tick !== 1'b1 && n < 300);
    end
  endtask : measure
  function automatic acef_route_s exp_route(input logic [3:0] c);
    acef_route_s r;
    r = '0;
    if (c <= 4'h5) r.pins = 6'h01 << c;
    r.gnd      = (c == 4'h8);
    r.half_ref = (c == 4'h9);
    r.full_ref = (c == 4'ha);
    r.half_pad = (c == 4'hb);
    return r;
  endfunction : exp_route
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    check(32'(flags), 32'h0);
    check(32'({mask_q, cfg_rdata, irq}), 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr_cfg(4'(c), 4'(15 - c), 1'b0, 3'(c));
      check(32'(pos_route), 32'(exp_route(4'(c))));
      check(32'(neg_route), 32'(exp_route(4'(15 - c))));
      check(32'(sig_bits), 32'(7 + c % 8));
      check(32'(sample_clks), 32'(32 << (c % 8)));
    end
    wr_cfg(4'h0, 4'h9, 1'b0, 3'h7);
    enable = 1'b1;
    @(negedge sys_clk);
    conv(32'h0000_0100);
    check(32'({flags, result_valid}), 32'h0);
    conv(32'h0000_1237);
    check(32'(result_valid), 32'h1);
    check(32'(result_data), 32'h1234);
    check(32'(flags), 32'h11);
    check(32'(irq), 32'h0);
    wr_ev(1'b0, 5'h10);
    check(32'(irq), 32'h1);
    wr_ev(1'b1, 5'h01);
    check(32'(flags), 32'h10);
    wr_ev(1'b1, 5'h10);
    check(32'(irq), 32'h0);
    dma_acc = 1'b1;
    conv(32'h0001_0000);
    check(32'(result_data), 32'h7ffc);
    check(32'(flags), 32'h12);
    conv(32'hfffe_0000);
    check(32'(result_data), 32'h8000);
    wr_ev(1'b1, 5'h1f);
    @(negedge sys_clk);
    flag_wr = 1'b1;
    flag_wdata = 5'h0c;
    dma_last = 1'b1;
    dma_half = 1'b1;
    @(negedge sys_clk);
    flag_wr = 1'b0;
    dma_last = 1'b0;
    dma_half = 1'b0;
    check(32'(flags), 32'h0c);
    wr_ev(1'b1, 5'h04);
    check(32'(flags), 32'h08);
    dma_acc = 1'b0;
    wr_cfg(4'h0, 4'h9, 1'b0, 3'h0);
    conv(32'h0000_7fff);
    check(32'(result_valid), 32'h0);
    check(32'(flags), 32'h08);
    conv(32'h0000_7fff);
    check(32'(result_data), 32'h7e00);
    check(32'(flags), 32'h19);
    dma_acc = 1'b1;
    wr_ev(1'b1, 5'h01);
    check(32'(flags), 32'h18);
    check(32'(irq), 32'h1);
    wr_ev(1'b0, 5'h00);
    check(32'(irq), 32'h0);
    measure();
    check(n, 32'd16);
    wr_cfg(4'h0, 4'h9, 1'b1, 3'h0);
    measure();
    check(n, 32'd100);
    print_verdict();
  end
endmodule : tb_adc_config_and_event_flags
`default_nettype wire
